// ### logic/ssrg_pkg.sv
// package: constants and types for the supply supervisor and reset gating block
package ssrg_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned HOLD_MS = 150;
    localparam int unsigned HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
    localparam int unsigned WDOG_MS = 1600;
    localparam int unsigned WDOG_CYC = (CLK_HZ / 1000) * WDOG_MS;
    localparam int unsigned CE_HOLD_US = 12;
    localparam int unsigned CE_HOLD_CYC = (CLK_HZ / 1000000) * CE_HOLD_US;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned CE_W = 16;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [1:0] SYNC_RST = 2'h3;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        CE_PASS = 3'h1,
        CE_HOLD = 3'h2,
        CE_BLOCK = 3'h4
    } ssrg_ce_t;
    typedef struct packed {
        logic supply_low;
        logic aux_low;
        logic backup_cell_input_above;
        logic main_above;
    } ssrg_sense_t;
    typedef struct packed {
        logic [1:0] mr_s;
        logic [1:0] wd_s;
        logic [1:0] ce_s;
        logic wd_prev;
        logic [CNT_W-1:0] hold_cnt;
        logic [CNT_W-1:0] wd_cnt;
        logic [CE_W-1:0] ce_cnt;
        ssrg_ce_t ce_st;
        logic rst_act;
        logic reset_out;
        logic reset_out_n;
        logic ce_out_n;
        logic on_backup_cell_input;
        logic backup_active_flag;
        logic rail_from_backup_cell_input;
    } ssrg_state_t;
endpackage : ssrg_pkg

// ### logic/ssrg_top.sv
// top: reset combining, watchdog, backup switchover and chip-enable gating
`timescale 1ns/1ns
module ssrg_top #(
    parameter int unsigned HOLD_CYC = ssrg_pkg::HOLD_CYC,
    parameter int unsigned WDOG_CYC = ssrg_pkg::WDOG_CYC,
    parameter int unsigned CE_HOLD_CYC = ssrg_pkg::CE_HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ssrg_pkg::ssrg_sense_t sense,
    input wire logic manual_reset_n,
    input wire logic watchdog_kick_in,
    input wire logic chip_enable_in_n,
    output logic reset_out,
    output logic reset_out_n,
    output logic chip_enable_out_n,
    output logic backup_active_flag,
    output logic rail_from_backup_cell_input
);
    ssrg_pkg::ssrg_state_t s_r;
    ssrg_pkg::ssrg_state_t s_nxt;
    logic src_level;
    logic wd_edge;
    logic wd_expire;
    logic hold_busy;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        // two-stage synchronisers
        s_nxt.mr_s = {s_r.mr_s[0], manual_reset_n};
        s_nxt.wd_s = {s_r.wd_s[0], watchdog_kick_in};
        s_nxt.ce_s = {s_r.ce_s[0], chip_enable_in_n};
        s_nxt.wd_prev = s_r.wd_s[1];
        wd_edge = s_r.wd_s[1] ^ s_r.wd_prev;
        src_level = sense.supply_low | ~s_r.mr_s[1] | sense.aux_low;
        wd_expire = !s_r.rst_act && (s_r.wd_cnt >= CNT(WDOG_CYC - 1));
        // watchdog timer
        if (s_r.rst_act || wd_edge) begin
            s_nxt.wd_cnt = '0;
        end else if (!wd_expire) begin
            s_nxt.wd_cnt = s_r.wd_cnt + CNT(1);
        end else begin
            s_nxt.wd_cnt = '0;
        end
        // hold counter restarts while any source is active
        hold_busy = s_r.hold_cnt != '0;
        if (src_level || wd_expire) begin
            s_nxt.hold_cnt = CNT(HOLD_CYC);
        end else if (hold_busy) begin
            s_nxt.hold_cnt = s_r.hold_cnt - CNT(1);
        end
        s_nxt.rst_act = src_level || wd_expire || hold_busy;
        s_nxt.reset_out = s_nxt.rst_act;
        s_nxt.reset_out_n = ~s_nxt.rst_act;
        // battery switchover with hysteresis
        if (!sense.supply_low) begin
            s_nxt.on_backup_cell_input = 1'b0;
        end else if (sense.backup_cell_input_above) begin
            s_nxt.on_backup_cell_input = 1'b1;
        end else if (sense.main_above) begin
            s_nxt.on_backup_cell_input = 1'b0;
        end
        s_nxt.rail_from_backup_cell_input = s_nxt.on_backup_cell_input;
        s_nxt.backup_active_flag = s_nxt.on_backup_cell_input;
        // chip-enable gating
        case (s_r.ce_st)
            ssrg_pkg::CE_PASS: begin
                if (s_nxt.rst_act) begin
                    if (!s_r.ce_s[1]) begin
                        s_nxt.ce_st = ssrg_pkg::CE_HOLD;
                        s_nxt.ce_cnt = CEC(CE_HOLD_CYC);
                    end else begin
                        s_nxt.ce_st = ssrg_pkg::CE_BLOCK;
                    end
                end
            end
            ssrg_pkg::CE_HOLD: begin
                if (s_r.ce_s[1] || s_r.ce_cnt <= CEC(1)) begin
                    s_nxt.ce_st = ssrg_pkg::CE_BLOCK;
                end else begin
                    s_nxt.ce_cnt = s_r.ce_cnt - CEC(1);
                end
                if (!s_nxt.rst_act) begin
                    s_nxt.ce_st = ssrg_pkg::CE_PASS;
                end
            end
            ssrg_pkg::CE_BLOCK: begin
                if (!s_nxt.rst_act) begin
                    s_nxt.ce_st = ssrg_pkg::CE_PASS;
                end
            end
            default: begin
                s_nxt.ce_st = ssrg_pkg::CE_BLOCK;
            end
        endcase
        case (s_nxt.ce_st)
            ssrg_pkg::CE_PASS: s_nxt.ce_out_n = s_r.ce_s[1];
            ssrg_pkg::CE_HOLD: s_nxt.ce_out_n = 1'b0;
            default: s_nxt.ce_out_n = 1'b1;
        endcase
    end

    function automatic logic [ssrg_pkg::CNT_W-1:0] CNT(input int unsigned v);
        CNT = v[ssrg_pkg::CNT_W-1:0];
    endfunction : CNT

    function automatic logic [ssrg_pkg::CE_W-1:0] CEC(input int unsigned v);
        CEC = v[ssrg_pkg::CE_W-1:0];
    endfunction : CEC

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.mr_s <= ssrg_pkg::SYNC_RST;
            s_r.wd_s <= ssrg_pkg::SYNC_RST;
            s_r.ce_s <= ssrg_pkg::SYNC_RST;
            s_r.wd_prev <= 1'b1;
            s_r.ce_st <= ssrg_pkg::CE_PASS;
            s_r.reset_out_n <= 1'b1;
            s_r.ce_out_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reset_out = s_r.reset_out;
    assign reset_out_n = s_r.reset_out_n;
    assign chip_enable_out_n = s_r.ce_out_n;
    assign backup_active_flag = s_r.backup_active_flag;
    assign rail_from_backup_cell_input = s_r.rail_from_backup_cell_input;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_reset_polarity: assert property (@(posedge clk) disable iff (!rst_n)
        reset_out == ~reset_out_n) else $error("reset outputs disagree");
    a_supply_low_rst: assert property (@(posedge clk) disable iff (!rst_n)
        sense.supply_low |=> reset_out) else $error("no reset on low supply");
    a_aux_low_rst: assert property (@(posedge clk) disable iff (!rst_n)
        sense.aux_low |=> reset_out) else $error("no reset on low aux");
    a_manual_rst: assert property (@(posedge clk) disable iff (!rst_n)
        !s_r.mr_s[1] |=> reset_out) else $error("no reset on manual");
    a_hold_after: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(src_level) && !wd_expire |=> reset_out [*2])
        else $error("reset dropped early");
    a_wdog_clear: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.rst_act |=> s_r.wd_cnt == '0) else $error("watchdog not cleared");
    a_wdog_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        wd_expire |=> reset_out && s_r.hold_cnt == CNT(HOLD_CYC))
        else $error("watchdog pulse missing");
    a_ce_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !chip_enable_out_n |-> !$past(s_r.ce_s[1]) || s_r.ce_st == ssrg_pkg::CE_HOLD)
        else $error("chip enable leaked");
    a_ce_block: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.ce_st == ssrg_pkg::CE_BLOCK |-> chip_enable_out_n)
        else $error("chip enable low while blocked");
    a_backup_cell_input_flag: assert property (@(posedge clk) disable iff (!rst_n)
        backup_active_flag |-> rail_from_backup_cell_input) else $error("flag mismatch");
    a_main_rail: assert property (@(posedge clk) disable iff (!rst_n)
        !sense.supply_low |=> !rail_from_backup_cell_input) else $error("rail not main");

    // ----------------------------------------
    // assertions: hold and watchdog timing, manual-reset synchroniser
    // ----------------------------------------
    a_hold_load: assert property (@(posedge clk) disable iff (!rst_n)
        src_level |=> s_r.hold_cnt == CNT(HOLD_CYC))
        else $error("hold count not reloaded");
    a_hold_release: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(reset_out) |-> s_r.hold_cnt == '0)
        else $error("reset released before hold ended");
    a_wdog_bound: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.wd_cnt < CNT(WDOG_CYC))
        else $error("watchdog count past limit");
    a_kick_clear: assert property (@(posedge clk) disable iff (!rst_n)
        wd_edge |=> s_r.wd_cnt == '0)
        else $error("kick did not clear watchdog");
    a_manual_sync: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.mr_s[1] == $past(manual_reset_n, 2))
        else $error("manual input not synchronised");

    // ----------------------------------------
    // assertions: switchover and chip enable
    // ----------------------------------------
    a_backup_cell_input_switch: assert property (@(posedge clk) disable iff (!rst_n)
        sense.supply_low && sense.backup_cell_input_above |=> backup_active_flag)
        else $error("no switch to battery");
    a_backup_cell_input_back: assert property (@(posedge clk) disable iff (!rst_n)
        sense.supply_low && !sense.backup_cell_input_above && sense.main_above |=> !backup_active_flag)
        else $error("no switch back to main");
    a_flag_low: assert property (@(posedge clk) disable iff (!rst_n)
        !sense.supply_low |=> !backup_active_flag)
        else $error("backup flag high on main");
    a_ce_hold_low: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.ce_st == ssrg_pkg::CE_HOLD |-> !chip_enable_out_n)
        else $error("chip enable not held low");
    a_ce_hold_len: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.ce_st == ssrg_pkg::CE_HOLD |-> s_r.ce_cnt <= CEC(CE_HOLD_CYC))
        else $error("chip enable hold too long");
    a_ce_idle_pass: assert property (@(posedge clk) disable iff (!rst_n)
        !reset_out |-> s_r.ce_st == ssrg_pkg::CE_PASS)
        else $error("chip enable gate closed out of reset");
    a_ce_out_rst: assert property (@(posedge clk) disable iff (!rst_n)
        reset_out && s_r.ce_st != ssrg_pkg::CE_HOLD |-> chip_enable_out_n)
        else $error("chip enable low during reset");
endmodule : ssrg_top

// ### verif/ssrg_host_model.sv
// host model: drives watchdog kicks and the chip-enable request
`timescale 1ns/1ns
module ssrg_host_model #(
    parameter int unsigned KICK_GAP = 10
) (
    input wire logic clk,
    input wire logic kick_en,
    input wire logic ce_req_n,
    output logic watchdog_kick_in,
    output logic chip_enable_in_n
);
    int unsigned gap_r = 0;
    initial watchdog_kick_in = 1'b0;
    initial chip_enable_in_n = 1'b1;
    always @(posedge clk) begin
        chip_enable_in_n <= #2 ce_req_n;
        gap_r <= (gap_r + 1) % KICK_GAP;
        if (kick_en && gap_r == 0) begin
            watchdog_kick_in <= #2 ~watchdog_kick_in;
        end
    end
endmodule : ssrg_host_model

// ### verif/test_ssrg_top.sv
// testbench: reset sources, watchdog, backup switch and chip-enable gating
`timescale 1ns/1ns
module test_ssrg_top;
    localparam int HC = 20;
    localparam int WC = 50;
    localparam int CC = 5;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    ssrg_pkg::ssrg_sense_t sense = '0;
    logic manual_reset_n = 1'b1;
    logic kick_en = 1'b1;
    logic ce_req_n = 1'b1;
    logic watchdog_kick_in, chip_enable_in_n, reset_out, reset_out_n;
    logic chip_enable_out_n, backup_active_flag, rail_from_backup_cell_input;
    int n_fail = 0;
    int n_checks = 0;
    int t;
    always #20 clk = ~clk;
    ssrg_top #(.HOLD_CYC(HC), .WDOG_CYC(WC), .CE_HOLD_CYC(CC)) u_ssrg_top (.clk(clk),
        .rst_n(rst_n), .sense(sense), .manual_reset_n(manual_reset_n),
        .watchdog_kick_in(watchdog_kick_in), .chip_enable_in_n(chip_enable_in_n),
        .reset_out(reset_out), .reset_out_n(reset_out_n), .chip_enable_out_n(chip_enable_out_n),
        .backup_active_flag(backup_active_flag), .rail_from_backup_cell_input(rail_from_backup_cell_input));
    ssrg_host_model u_ssrg_host_model (.clk(clk), .kick_en(kick_en), .ce_req_n(ce_req_n),
        .watchdog_kick_in(watchdog_kick_in), .chip_enable_in_n(chip_enable_in_n));
    task automatic chk(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic wait_rst(input logic v, input int lim, output int n);
        n = 0;
        while (reset_out !== v && n < lim) begin
            step(1);
            n++;
        end
    endtask : wait_rst
    task automatic set_src(input int k, input logic v);
        case (k)
            0: sense.supply_low = v;
            1: sense.aux_low = v;
            default: manual_reset_n = ~v;
        endcase
    endtask : set_src
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #100000;
        n_fail++;
        end_of_test();
    end
    initial begin
        void'($urandom(64926));
        step(2);
        rst_n = 1'b1;
        step(1);
        chk(reset_out, 1'b0);
        chk(reset_out_n, 1'b1);
        for (int k = 0; k < 3; k++) begin
            set_src(k, 1'b1);
            wait_rst(1'b1, 6, t);
            chk(t < 6, 1'b1);
            step($urandom_range(3, 30));
            chk(reset_out_n, 1'b0);
            set_src(k, 1'b0);
            wait_rst(1'b0, HC + 8, t);
            chk(t >= HC - 1 && t <= HC + 4, 1'b1);
        end
        sense.supply_low = 1'b1;
        sense.backup_cell_input_above = 1'b1;
        step(4);
        chk(rail_from_backup_cell_input & backup_active_flag, 1'b1);
        sense.backup_cell_input_above = 1'b0;
        step(4);
        chk(rail_from_backup_cell_input, 1'b1);
        sense.main_above = 1'b1;
        step(4);
        chk(rail_from_backup_cell_input | backup_active_flag, 1'b0);
        sense.main_above = 1'b0;
        sense.backup_cell_input_above = 1'b1;
        sense.supply_low = 1'b0;
        step(4);
        chk(rail_from_backup_cell_input, 1'b0);
        sense.backup_cell_input_above = 1'b0;
        wait_rst(1'b0, HC + 8, t);
        ce_req_n = 1'b0;
        step(6);
        chk(chip_enable_out_n, 1'b0);
        sense.supply_low = 1'b1;
        step(3);
        chk(chip_enable_out_n, 1'b0);
        step(CC + 2);
        chk(chip_enable_out_n, 1'b1);
        ce_req_n = 1'b1;
        step(4);
        ce_req_n = 1'b0;
        step(6);
        chk(chip_enable_out_n, 1'b1);
        sense.supply_low = 1'b0;
        wait_rst(1'b0, HC + 8, t);
        step(4);
        chk(chip_enable_out_n, 1'b0);
        ce_req_n = 1'b1;
        kick_en = 1'b0;
        wait_rst(1'b1, WC + 10, t);
        chk(t >= WC - 14 && t < WC + 10, 1'b1);
        wait_rst(1'b0, HC + 8, t);
        chk(t >= HC - 2 && t <= HC + 4, 1'b1);
        wait_rst(1'b1, WC + 10, t);
        chk(t >= WC - 2 && t < WC + 10, 1'b1);
        wait_rst(1'b0, HC + 8, t);
        kick_en = 1'b1;
        step(3 * WC);
        chk(reset_out, 1'b0);
        end_of_test();
    end
endmodule : test_ssrg_top
